/* hw/csc_pkg.sv */
// csc_pkg: register offsets, field positions, reset values and carrier
// types for the cpu status / core control register bank.
// assumes a 16-bit data path carried in the low half of a 32-bit bus.
`default_nettype none
package csc_pkg;
  // ------------------------------------------------------------------
  // register map (word aligned byte addresses)
  // ------------------------------------------------------------------
  localparam logic [3:0] CSC_OFF_FLAGS = 4'h0;  // cpu_flags
  localparam logic [3:0] CSC_OFF_CONFIG = 4'h4; // core_config
  localparam logic [3:0] CSC_OFF_CTRL = 4'h8;   // not decoded; reads return zero
  localparam logic [15:0] CSC_FLAGS_RST = 16'h0000;
  localparam logic [15:0] CSC_CONFIG_RST = 16'h0020;
  // cpu_flags field positions
  localparam int CSC_F_OA = 15;
  localparam int CSC_F_OB = 14;
  localparam int CSC_F_SA = 13;
  localparam int CSC_F_SB = 12;
  localparam int CSC_F_OAB = 11;
  localparam int CSC_F_SAB = 10;
  localparam int CSC_F_DA = 9;
  localparam int CSC_F_DC = 8;
  localparam int CSC_F_IPL_LO = 5;
  localparam int CSC_F_RA = 4;
  localparam int CSC_F_N = 3;
  localparam int CSC_F_OV = 2;
  localparam int CSC_F_Z = 1;
  localparam int CSC_F_C = 0;
  // core_config field positions
  localparam int CSC_C_VAR = 15;
  localparam int CSC_C_US_LO = 12;
  localparam int CSC_C_EDT = 11;
  localparam int CSC_C_DL_LO = 8;
  localparam int CSC_C_ACC_A_CLAMP_EN = 7;
  localparam int CSC_C_ACC_B_CLAMP_EN = 6;
  localparam int CSC_C_STORE_CLAMP_EN = 5;
  localparam int CSC_C_CLAMP_WIDTH_SELECT = 4;
  localparam int CSC_C_PRIORITY_LEVEL_MSB = 3;
  localparam int CSC_C_SFA = 2;
  localparam int CSC_C_RND = 1;
  localparam int CSC_C_IF = 0;
  // writable bit masks
  localparam logic [15:0] CSC_FLAGS_WMASK = 16'hF1EF; // minus DA RA EITHER_ACC_WRAP EITHER_ACC_CLAMP_STICKY
  localparam logic [15:0] CSC_CONFIG_WMASK = 16'hB0FB;
  localparam logic [2:0] CSC_IPL_MAX = 3'h7;
  localparam logic [31:0] CSC_UNMAPPED = 32'h00000000;

  // multiply sign modes
  typedef enum logic [1:0] {
    CSC_MUL_SIGNED = 2'b00,
    CSC_MUL_UNSIGNED = 2'b01,
    CSC_MUL_MIXED = 2'b10,
    CSC_MUL_RSVD = 2'b11
  } csc_mul_t;

  // flag updates from alu / dsp engine, each with its own update strobe
  typedef struct packed {
    logic alu_upd;  // alu op that affects c/dc/n/ov
    logic carry;
    logic half_carry;
    logic negative;
    logic signed_wrap;
    logic zero_upd; // op affects z
    logic zero;
    logic acc_a_upd;
    logic acc_a_wrap;
    logic acc_a_clamp;
    logic acc_b_upd;
    logic acc_b_wrap;
    logic acc_b_clamp;
  } csc_evt_t;

  // loop engine state
  typedef struct packed {
    logic repeat_running;
    logic [2:0] loop_nest_depth;
    logic stack_frame_active;
    logic nesting_disable;
    logic priority_level_msb_set;  // exception entry raising level above 7
  } csc_loop_t;

  // decoded configuration to the datapath
  typedef struct packed {
    logic var_latency;
    csc_mul_t multiply_sign_select;
    logic acc_a_clamp_en;
    logic acc_b_clamp_en;
    logic store_clamp_en;
    logic clamp_width_select;
    logic rounding_select;
    logic integer_mode;
    logic full_range_frame;
  } csc_cfg_t;
endpackage : csc_pkg
`default_nettype wire

/* hw/csc_regs.sv */
// csc_regs: cpu status and core control registers behind an avalon-mm
// slave. alu, dsp and loop logic update flags through event structs.
// assumes all event inputs are synchronous to clk.
`default_nettype none

module csc_regs (
  input wire logic clk,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // datapath side
  input wire csc_pkg::csc_evt_t evt,
  input wire csc_pkg::csc_loop_t loop_st,
  input wire logic loop_running,
  output csc_pkg::csc_cfg_t cfg,
  output logic [3:0] cpu_priority_level,
  output logic user_irq_disable,
  output logic loop_early_exit
);
  import csc_pkg::*;

  // ------------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------------
  // one wait state: the request is held, acked on the second edge
  logic ack_ff;         // answer cycle marker
  logic [31:0] rdata_ff; // captured read data
  logic req;            // request pending and not yet acked
  logic wr_go;          // write takes effect this edge
  logic [15:0] be_mask; // low two byte lanes expanded
  logic [15:0] wdat;

  assign req = (avs_read | avs_write) & ~ack_ff;
  assign wr_go = avs_write & ack_ff;
  assign be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wdat = avs_writedata[15:0];
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign avs_readdata = rdata_ff;
  assign avs_response = 2'b00; // unmapped reads return zero, okay

  // ack toggles one cycle after each request is seen
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  // ------------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------------
  logic acc_a_wrap_flag_ff;
  logic acc_b_wrap_flag_ff;
  logic acc_a_clamp_sticky_ff;
  logic acc_b_clamp_sticky_ff;
  logic half_carry_flag_ff;
  logic [2:0] ipl_lo_ff;     // low three level bits
  logic negative_ff;
  logic signed_wrap_flag_ff;
  logic zero_ff;
  logic carry_ff;
  logic [15:0] cfg_ff;       // writable core_config bits
  logic priority_level_msb_ff;
  logic edt_ff;              // one-cycle early exit pulse

  logic wr_flags;  // write to cpu_flags this edge
  logic wr_cfg;    // write to core_config this edge
  logic [15:0] flags_rd;
  logic [15:0] cfg_rd;
  logic either_acc_wrap;
  logic either_acc_clamp_sticky;
  logic [15:0] fw;  // cpu_flags write value merged with lanes

  assign wr_flags = wr_go & (avs_address == CSC_OFF_FLAGS);
  assign wr_cfg = wr_go & (avs_address == CSC_OFF_CONFIG);
  assign fw = (wdat & be_mask) | (flags_rd & ~be_mask);

  assign either_acc_wrap = acc_a_wrap_flag_ff | acc_b_wrap_flag_ff;
  assign either_acc_clamp_sticky =
    acc_a_clamp_sticky_ff | acc_b_clamp_sticky_ff;

  // ------------------------------------------------------------------
  // accumulator flags
  // ------------------------------------------------------------------
  // hardware update wins over a same-cycle software write or clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_a_wrap_flag_ff <= 1'b0;
      acc_b_wrap_flag_ff <= 1'b0;
    end else begin
      if (evt.acc_a_upd) begin
        acc_a_wrap_flag_ff <= evt.acc_a_wrap;
      end else if (wr_flags) begin
        acc_a_wrap_flag_ff <= fw[CSC_F_OA];
      end
      if (evt.acc_b_upd) begin
        acc_b_wrap_flag_ff <= evt.acc_b_wrap;
      end else if (wr_flags) begin
        acc_b_wrap_flag_ff <= fw[CSC_F_OB];
      end
    end
  end

  // sticky saturation: a write of zero to the combined bit clears both,
  // but a saturation event in the same cycle still sets its flag
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_a_clamp_sticky_ff <= 1'b0;
      acc_b_clamp_sticky_ff <= 1'b0;
    end else begin
      if (evt.acc_a_upd & evt.acc_a_clamp) begin
        acc_a_clamp_sticky_ff <= 1'b1;
      end else if (wr_flags) begin
        acc_a_clamp_sticky_ff <= fw[CSC_F_SA] & fw[CSC_F_SAB];
      end
      if (evt.acc_b_upd & evt.acc_b_clamp) begin
        acc_b_clamp_sticky_ff <= 1'b1;
      end else if (wr_flags) begin
        acc_b_clamp_sticky_ff <= fw[CSC_F_SB] & fw[CSC_F_SAB];
      end
    end
  end

  // ------------------------------------------------------------------
  // alu condition flags
  // ------------------------------------------------------------------
  // sources compute carry at bit 4/8 and msb; this bank only stores them
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      half_carry_flag_ff <= 1'b0;
      negative_ff <= 1'b0;
      signed_wrap_flag_ff <= 1'b0;
      carry_ff <= 1'b0;
    end else if (evt.alu_upd) begin
      half_carry_flag_ff <= evt.half_carry;
      negative_ff <= evt.negative;
      signed_wrap_flag_ff <= evt.signed_wrap;
      carry_ff <= evt.carry;
    end else if (wr_flags) begin
      half_carry_flag_ff <= fw[CSC_F_DC];
      negative_ff <= fw[CSC_F_N];
      signed_wrap_flag_ff <= fw[CSC_F_OV];
      carry_ff <= fw[CSC_F_C];
    end
  end

  // zero only clears on a non-zero result; a zero result sets it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      zero_ff <= 1'b0;
    end else if (evt.zero_upd) begin
      if (!evt.zero) begin
        zero_ff <= 1'b0;
      end else begin
        zero_ff <= 1'b1;
      end
    end else if (wr_flags) begin
      zero_ff <= fw[CSC_F_Z];
    end
  end

  // ------------------------------------------------------------------
  // priority level
  // ------------------------------------------------------------------
  // level bits frozen against software while nesting is disabled
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ipl_lo_ff <= 3'h0;
    end else if (wr_flags & ~loop_st.nesting_disable) begin
      ipl_lo_ff <= fw[CSC_F_IPL_LO +: 3];
    end
  end

  // msb is set by exception entry; software may only clear it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      priority_level_msb_ff <= 1'b0;
    end else if (loop_st.priority_level_msb_set) begin
      priority_level_msb_ff <= 1'b1;
    end else if (wr_cfg & be_mask[CSC_C_PRIORITY_LEVEL_MSB] & ~wdat[CSC_C_PRIORITY_LEVEL_MSB]) begin
      priority_level_msb_ff <= 1'b0;
    end
  end

  assign cpu_priority_level = {priority_level_msb_ff, ipl_lo_ff};
  assign user_irq_disable =
    priority_level_msb_ff | (ipl_lo_ff == CSC_IPL_MAX);

  // ------------------------------------------------------------------
  // core configuration
  // ------------------------------------------------------------------
  // only writable bits are stored; read-only fields come from live state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_ff <= CSC_CONFIG_RST;
    end else if (wr_cfg) begin
      cfg_ff <= ((wdat & be_mask) | (cfg_ff & ~be_mask))
                & CSC_CONFIG_WMASK & ~(16'h1 << CSC_C_EDT)
                & ~(16'h1 << CSC_C_PRIORITY_LEVEL_MSB);
    end
  end

  // early exit is a pulse; ignored when no loop runs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      edt_ff <= 1'b0;
    end else begin
      edt_ff <= wr_cfg & be_mask[CSC_C_EDT] & wdat[CSC_C_EDT]
                & loop_running;
    end
  end
  assign loop_early_exit = edt_ff;

  // decoded outputs to the datapath
  always_comb begin
    cfg.var_latency = cfg_ff[CSC_C_VAR];
    cfg.multiply_sign_select =
      csc_mul_t'(cfg_ff[CSC_C_US_LO +: 2]);
    cfg.acc_a_clamp_en = cfg_ff[CSC_C_ACC_A_CLAMP_EN];
    cfg.acc_b_clamp_en = cfg_ff[CSC_C_ACC_B_CLAMP_EN];
    cfg.store_clamp_en = cfg_ff[CSC_C_STORE_CLAMP_EN];
    cfg.clamp_width_select = cfg_ff[CSC_C_CLAMP_WIDTH_SELECT];
    cfg.rounding_select = cfg_ff[CSC_C_RND];
    cfg.integer_mode = cfg_ff[CSC_C_IF];
    cfg.full_range_frame = loop_st.stack_frame_active;
  end

  // ------------------------------------------------------------------
  // read views
  // ------------------------------------------------------------------
  always_comb begin
    flags_rd = 16'h0000;
    flags_rd[CSC_F_OA] = acc_a_wrap_flag_ff;
    flags_rd[CSC_F_OB] = acc_b_wrap_flag_ff;
    flags_rd[CSC_F_SA] = acc_a_clamp_sticky_ff;
    flags_rd[CSC_F_SB] = acc_b_clamp_sticky_ff;
    flags_rd[CSC_F_OAB] = either_acc_wrap;
    flags_rd[CSC_F_SAB] = either_acc_clamp_sticky;
    flags_rd[CSC_F_DA] = loop_running;
    flags_rd[CSC_F_DC] = half_carry_flag_ff;
    flags_rd[CSC_F_IPL_LO +: 3] = ipl_lo_ff;
    flags_rd[CSC_F_RA] = loop_st.repeat_running;
    flags_rd[CSC_F_N] = negative_ff;
    flags_rd[CSC_F_OV] = signed_wrap_flag_ff;
    flags_rd[CSC_F_Z] = zero_ff;
    flags_rd[CSC_F_C] = carry_ff;
  end

  // edt reads zero because it is never stored in cfg_ff
  always_comb begin
    cfg_rd = cfg_ff;
    cfg_rd[CSC_C_DL_LO +: 3] = loop_st.loop_nest_depth;
    cfg_rd[CSC_C_PRIORITY_LEVEL_MSB] = priority_level_msb_ff;
    cfg_rd[CSC_C_SFA] = loop_st.stack_frame_active;
  end

  // read data captured on the wait cycle, stands at the ack edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_ff <= 32'h00000000;
    end else if (avs_read & ~ack_ff) begin
      unique case (avs_address)
        CSC_OFF_FLAGS: rdata_ff <= {16'h0000, flags_rd};
        CSC_OFF_CONFIG: rdata_ff <= {16'h0000, cfg_rd};
        default: rdata_ff <= CSC_UNMAPPED;
      endcase
    end
  end
endmodule : csc_regs
`default_nettype wire

/* verif/csc_regs_checker.sv */
// csc_regs_checker: port-level checks for the cpu status / core control bank.
// assumes one clock domain and a master that idles a cycle between requests.
`default_nettype none
module csc_regs_checker
  import csc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire csc_pkg::csc_loop_t loop_st,
  input wire logic loop_running,
  input wire csc_pkg::csc_cfg_t cfg,
  input wire logic [3:0] cpu_priority_level,
  input wire logic user_irq_disable,
  input wire logic loop_early_exit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  logic wr_flags; // completed write to cpu_flags
  logic wr_cfg; // completed write to core_config
  assign wr_flags = avs_write && !avs_waitrequest
    && avs_address == CSC_OFF_FLAGS;
  assign wr_cfg = avs_write && !avs_waitrequest
    && avs_address == CSC_OFF_CONFIG;
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  chk_req_wait: assert property ($rose(avs_read || avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest)
    else $error("request not answered after one wait state");
  chk_exit_cause: assert property ($rose(loop_early_exit) |->
    $past(wr_cfg && avs_writedata[CSC_C_EDT] && loop_running))
    else $error("early exit without a loop-end write");
  chk_exit_pulse: assert property (loop_early_exit |=>
    !loop_early_exit) else $error("early exit longer than one cycle");
  chk_reset_vals: assert property ($fell(reset) |->
    cfg.store_clamp_en && !cfg.var_latency)
    else $error("config outputs wrong after reset");
  chk_irq_off: assert property (user_irq_disable ==
    (cpu_priority_level[3] || cpu_priority_level[2:0] == CSC_IPL_MAX))
    else $error("user interrupt disable wrong for level");
  chk_level_hold: assert property (wr_flags &&
    loop_st.nesting_disable |=> $stable(cpu_priority_level[2:0]))
    else $error("level bits written while nesting disabled");
  chk_msb_set: assert property (loop_st.priority_level_msb_set |->
    ##[1:2] cpu_priority_level[3]) else $error("level msb not set");
  chk_cfg_low: assert property (wr_cfg && avs_byteenable[0]
    |=> {cfg.acc_a_clamp_en, cfg.acc_b_clamp_en, cfg.store_clamp_en,
     cfg.clamp_width_select, cfg.rounding_select, cfg.integer_mode}
    == {$past(avs_writedata[7:4]), $past(avs_writedata[1:0])})
    else $error("low config byte not applied");
  chk_cfg_high: assert property (wr_cfg && avs_byteenable[1] |=>
    {cfg.var_latency, cfg.multiply_sign_select}
    == {$past(avs_writedata[15]), $past(avs_writedata[13:12])})
    else $error("high config byte not applied");
  chk_frame_range: assert property ($stable(loop_st.stack_frame_active)
    |-> cfg.full_range_frame == loop_st.stack_frame_active)
    else $error("full range frame does not follow input");
endmodule : csc_regs_checker

bind csc_regs csc_regs_checker chk_u (.clk, .reset, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_waitrequest, .loop_st, .loop_running, .cfg, .cpu_priority_level,
  .user_irq_disable, .loop_early_exit);
`default_nettype wire

/* verif/csc_regs_bench.sv */
// csc_regs_bench: self-checking bench for the register bank.
// assumes a one-wait-state avalon-mm slave and flags/config at 0x0/0x4.
`default_nettype none
module csc_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import csc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h3; // only the low half-word is mapped
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  csc_evt_t evt = '0;
  csc_loop_t loop_st = '0;
  logic loop_running = 1'b0;
  csc_cfg_t cfg;
  logic [3:0] cpu_priority_level;
  logic user_irq_disable;
  logic loop_early_exit;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0; // hang guard
  int exit_cnt = 0; // early exit pulses seen
  logic [15:0] rd; // last read data
  // 200 MHz clock
  always #2.5 clk = ~clk;
  csc_regs dut_u (.clk, .reset, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .avs_response, .evt, .loop_st, .loop_running, .cfg,
    .cpu_priority_level, .user_irq_disable, .loop_early_exit);
  // ------------------------------------------------------------
  // common tasks
  // ------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  // one avalon transfer; holds everything until waitrequest is low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [15:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[15:0];
    check({30'h0, avs_response}, 32'h0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0000);
    check({16'h0000, rd}, {16'h0000, exp});
  endtask : rd_chk
  // one-cycle event strobe from the alu / dsp side
  task automatic pulse(input csc_evt_t v);
    @(posedge clk);
    evt <= v;
    @(posedge clk);
    evt <= '0;
  endtask : pulse
  // level of priority bits and disable, settled
  task automatic lvl_chk(input logic [15:0] d, input logic [31:0] exp);
    bus(1'b1, CSC_OFF_CONFIG, d);
    @(negedge clk);
    check({27'h0, user_irq_disable, cpu_priority_level}, exp);
  endtask : lvl_chk
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rd_chk(CSC_OFF_FLAGS, 16'h0000);
    rd_chk(CSC_OFF_CONFIG, 16'h0020);
    bus(1'b1, 4'hC, 16'hFFFF); // unmapped write is dropped
    rd_chk(4'hC, 16'h0000);
  endtask : t_reset
  task automatic t_acc();
    pulse(13'h0038); // acc a wraps and clamps
    rd_chk(CSC_OFF_FLAGS, 16'hAC00);
    pulse(13'h0020); // acc a clean result
    rd_chk(CSC_OFF_FLAGS, 16'h2400);
    pulse(13'h0006); // acc b wraps only
    rd_chk(CSC_OFF_FLAGS, 16'h6C00);
    bus(1'b1, CSC_OFF_FLAGS, 16'h4000); // whole word write
    rd_chk(CSC_OFF_FLAGS, 16'h4800);
    bus(1'b1, CSC_OFF_FLAGS, 16'h1400); // whole word write
    rd_chk(CSC_OFF_FLAGS, 16'h1400);
    bus(1'b1, CSC_OFF_FLAGS, 16'h0000);
  endtask : t_acc
  task automatic t_alu();
    pulse(13'h1F00); // carry, half carry, negative, signed wrap
    rd_chk(CSC_OFF_FLAGS, 16'h010D);
    pulse(13'h00C0); // zero result
    rd_chk(CSC_OFF_FLAGS, 16'h010F);
    pulse(13'h1000); // clean alu result leaves zero alone
    rd_chk(CSC_OFF_FLAGS, 16'h0002);
    pulse(13'h0080); // non-zero result
    rd_chk(CSC_OFF_FLAGS, 16'h0000);
  endtask : t_alu
  task automatic t_loop();
    loop_running <= 1'b1;
    loop_st <= 7'h7C; // repeat on, depth 7, frame active
    rd_chk(CSC_OFF_FLAGS, 16'h0210);
    rd_chk(CSC_OFF_CONFIG, 16'h0724);
    bus(1'b1, CSC_OFF_CONFIG, 16'hFFFF);
    rd_chk(CSC_OFF_CONFIG, 16'hB7F7);
    check({22'h0, cfg}, 32'h3FF);
    loop_running <= 1'b0;
    bus(1'b1, CSC_OFF_CONFIG, 16'hFFFF); // no loop, no exit pulse
    rd_chk(CSC_OFF_CONFIG, 16'hB7F7);
    check(32'(exit_cnt), 32'h1);
    loop_st <= '0;
    // every multiply sign code, reserved one included
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, CSC_OFF_CONFIG, {2'b00, i[1:0], 12'h000});
      @(negedge clk);
      check({30'h0, cfg.multiply_sign_select}, i);
    end
  endtask : t_loop
  task automatic t_prio();
    bus(1'b1, CSC_OFF_FLAGS, 16'h00E0);
    lvl_chk(16'h0000, 32'h17);
    bus(1'b1, CSC_OFF_FLAGS, 16'h0060);
    lvl_chk(16'h0000, 32'h03);
    loop_st <= 7'h02; // nesting disabled
    bus(1'b1, CSC_OFF_FLAGS, 16'h00A0);
    rd_chk(CSC_OFF_FLAGS, 16'h0060);
    @(posedge clk);
    loop_st <= 7'h03; // exception raises level msb
    @(posedge clk);
    loop_st <= '0;
    lvl_chk(16'h0028, 32'h1B);
    lvl_chk(16'h0020, 32'h03);
  endtask : t_prio
  // ------------------------------------------------------------
  // hang guard and pulse counting
  // ------------------------------------------------------------
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (loop_early_exit === 1'b1) exit_cnt <= exit_cnt + 1;
    if (cycles == 4000) begin
      err_count++;
      final_report();
    end
  end
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_acc();
    t_alu();
    t_loop();
    t_prio();
    final_report();
  end
endmodule : csc_regs_bench
`default_nettype wire
